// ===== rtl/dmac_pkg.sv
// Shared constants and types for the DMA channel and its link partner
package dmac_pkg;

	// ****************************************
	// Register byte offsets
	// ****************************************
	localparam logic [11:0] OFF_CTRL = 12'h000;
	localparam logic [11:0] OFF_SRC_ADDR = 12'h004;
	localparam logic [11:0] OFF_DST_ADDR = 12'h008;
	localparam logic [11:0] OFF_ITEM_ADDR = 12'h00C;
	localparam logic [11:0] OFF_IRQ_STAT = 12'h010;
	localparam logic [11:0] OFF_IRQ_MASK = 12'h014;
	localparam logic [11:0] OFF_CTL_HIGH = 12'h074;
	localparam logic [11:0] OFF_CFG_LOW = 12'h098;
	localparam logic [11:0] OFF_CFG_HIGH = 12'h09C;

	// ****************************************
	// Reset values
	// ****************************************
	localparam logic [31:0] RST_CTL_HIGH = 32'h0000_0000;
	localparam logic [31:0] RST_CFG_LOW = 32'h0000_0E20;

	// ****************************************
	// Field positions
	// ****************************************
	localparam int CTL_DONE_BIT = 12;
	localparam int CTL_CNT_W = 10;
	localparam int CFG_SRC_POL_BIT = 19;
	localparam int CFG_DST_POL_BIT = 18;
	localparam int CFG_SRC_SEL_BIT = 11;
	localparam int CFG_DST_SEL_BIT = 10;
	localparam int CFG_EMPTY_BIT = 9;
	localparam int CFG_SUSP_BIT = 8;
	localparam int CFG_RANK_LSB = 5;
	localparam int CFGH_SRC_PORT_LSB = 7;
	localparam int CFGH_DST_PORT_LSB = 11;
	localparam int CTRL_EN_BIT = 0;
	localparam int CTRL_WB_BIT = 1;
	localparam int CTRL_SRC_MEM_BIT = 2;
	localparam int CTRL_DST_MEM_BIT = 3;
	localparam int CTRL_FLOW_LSB = 4;
	localparam int CTRL_WIDTH_LSB = 6;
	localparam int CTRL_SW_SRC_BIT = 9;
	localparam int CTRL_SW_DST_BIT = 10;
	localparam int IRQ_BLOCK_BIT = 0;
	localparam int IRQ_WB_BIT = 1;

	// ****************************************
	// Counts and codes
	// ****************************************
	localparam logic [9:0] CNT_MAX = 10'h3FF;
	localparam logic [2:0] ITEM_SIZE = 3'h2;
	localparam int HW_REQ_N = 16;
	localparam int MEM_DEPTH = 16;

	typedef enum logic [1:0] {
		FLOW_DMA = 2'h0,
		FLOW_SRC = 2'h1,
		FLOW_DST = 2'h2,
		FLOW_RSVD = 2'h3
	} dmac_flow_e;

	typedef enum logic [3:0] {
		ST_IDLE = 4'h1,
		ST_READ = 4'h2,
		ST_WRITE = 4'h4,
		ST_WBACK = 4'h8
	} dmac_state_e;

endpackage

// ===== rtl/dmac_link_if.sv
// Link between the DMA channel and the peripheral/memory side
`timescale 1ns/1ps
`default_nettype none
interface dmac_link_if;
	logic [15:0] hw_src_req;
	logic [15:0] hw_dst_req;
	logic src_last;
	logic dst_last;
	logic bus_req;
	logic [2:0] bus_rank;
	logic bus_gnt;
	logic m_valid;
	logic m_write;
	logic [2:0] m_size;
	logic [31:0] m_addr;
	logic [31:0] m_wdata;
	logic s_ready;
	logic [31:0] s_rdata;

	modport dev (
		input hw_src_req, hw_dst_req, src_last, dst_last, bus_gnt, s_ready, s_rdata,
		output bus_req, bus_rank, m_valid, m_write, m_size, m_addr, m_wdata
	);
	modport peer (
		output hw_src_req, hw_dst_req, src_last, dst_last, bus_gnt, s_ready, s_rdata,
		input bus_req, bus_rank, m_valid, m_write, m_size, m_addr, m_wdata
	);
endinterface
`default_nettype wire

// ===== rtl/dmac_req_sel.sv
// Request path selection for one side of the channel
`timescale 1ns/1ps
`default_nettype none
module dmac_req_sel (
	input wire logic [15:0] hw_req,
	input wire logic [3:0] port_number,
	input wire logic polarity,
	input wire logic path_select,
	input wire logic sw_req,
	input wire logic is_mem,
	output logic req
);
	always_comb begin
		if (is_mem) begin
			req = 1'b1;
		end else if (path_select) begin
			req = sw_req;
		end else begin
			req = hw_req[port_number] ^ polarity;
		end
	end
endmodule
`default_nettype wire

// ===== rtl/dmac_channel.sv
// DMA channel: APB registers, request handling, transfer engine, write-back
// Operation
// - Write-back puts done-flagged control word into item
// - Item accesses are aligned fixed 32-bit words
// - Software clears item done flags before enabling
// - DMA flow: perform programmed count of beats
// - Count readback shows items read from source
// - Peripheral flow: count readback saturates at 1023
// - Source polarity bit: 0 high, 1 low
// - Destination polarity bit: 0 high, 1 low
// - Source path select: hardware or software requests
// - Destination path select: hardware or software requests
// - FIFO empty bit reflects channel buffer contents
// - Suspend stops source reads until cleared
// - Software suspends, waits empty, then disables
// - Rank field orders channels, seven highest
// - Software keeps rank within zero to two
// - Hardware source uses numbered request line
`timescale 1ns/1ps
`default_nettype none
module dmac_channel
	import dmac_pkg::*;
(
	input wire logic core_clk,
	input wire logic resetn,
	input wire logic clk_en,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	output logic irq,
	output logic block_done,
	dmac_link_if.dev link
);

	// ****************************************
	// Registers
	// ****************************************
	logic enable_reg, wb_en_reg, src_mem_reg, dst_mem_reg, sw_src_reg, sw_dst_reg;
	logic [1:0] flow_reg;
	logic [2:0] width_reg;
	logic done_reg;
	logic [9:0] block_size_reg;
	logic src_pol_reg, dst_pol_reg, src_sel_reg, dst_sel_reg, suspend_reg;
	logic [2:0] rank_reg;
	logic [3:0] src_port_reg, dst_port_reg;
	logic [31:0] src_addr_reg, dst_addr_reg, item_addr_reg;
	logic [1:0] irq_stat_reg, irq_mask_reg;
	logic [9:0] cnt_reg;
	logic started_reg, last_reg, hold_valid_reg;
	logic [31:0] hold_reg;
	dmac_state_e state_reg;

	logic acc, wr, rd;
	logic [31:0] rd_value;
	logic start, finish, src_req, dst_req, want_rd, want_wr;
	logic [9:0] count_view;
	logic [31:0] step;
	logic [31:0] ctl_high_word;
	logic [1:0] irq_set;

	function automatic logic is_mapped(input logic [11:0] a);
		is_mapped = (a == OFF_CTRL) || (a == OFF_SRC_ADDR) || (a == OFF_DST_ADDR) ||
			(a == OFF_ITEM_ADDR) || (a == OFF_IRQ_STAT) || (a == OFF_IRQ_MASK) ||
			(a == OFF_CTL_HIGH) || (a == OFF_CFG_LOW) || (a == OFF_CFG_HIGH);
	endfunction

	function automatic logic wr_to(input logic [11:0] a, input logic [11:0] off);
		wr_to = (a == off);
	endfunction

	assign acc = psel && penable && pready;
	assign wr = acc && pwrite;
	assign rd = acc && !pwrite;
	assign start = wr && wr_to(paddr, OFF_CTRL) && pwdata[CTRL_EN_BIT] && !enable_reg;
	assign count_view = started_reg ? cnt_reg : block_size_reg;
	assign ctl_high_word = {19'h0, done_reg, 2'h0, count_view};
	assign step = 32'h1 << width_reg;

	// ****************************************
	// Request paths
	// ****************************************
	dmac_req_sel u_src_sel (
		.hw_req(link.hw_src_req),
		.port_number(src_port_reg),
		.polarity(src_pol_reg),
		.path_select(src_sel_reg),
		.sw_req(sw_src_reg),
		.is_mem(src_mem_reg),
		.req(src_req)
	);
	dmac_req_sel u_dst_sel (
		.hw_req(link.hw_dst_req),
		.port_number(dst_port_reg),
		.polarity(dst_pol_reg),
		.path_select(dst_sel_reg),
		.sw_req(sw_dst_reg),
		.is_mem(dst_mem_reg),
		.req(dst_req)
	);

	// Suspend only blocks source reads; buffered data still drains
	assign want_rd = enable_reg && !hold_valid_reg && !suspend_reg && !last_reg && src_req;
	assign want_wr = enable_reg && hold_valid_reg && dst_req;

	// ****************************************
	// APB read mux and answer
	// ****************************************
	always_comb begin
		rd_value = 32'h0;
		unique case (paddr)
			OFF_CTRL: rd_value = {21'h0, sw_dst_reg, sw_src_reg, width_reg, flow_reg,
				dst_mem_reg, src_mem_reg, wb_en_reg, enable_reg};
			OFF_SRC_ADDR: rd_value = src_addr_reg;
			OFF_DST_ADDR: rd_value = dst_addr_reg;
			OFF_ITEM_ADDR: rd_value = item_addr_reg;
			OFF_IRQ_STAT: rd_value = {30'h0, irq_stat_reg};
			OFF_IRQ_MASK: rd_value = {30'h0, irq_mask_reg};
			OFF_CTL_HIGH: rd_value = ctl_high_word;
			OFF_CFG_LOW: rd_value = {12'h0, src_pol_reg, dst_pol_reg, 6'h0, src_sel_reg, dst_sel_reg,
				!hold_valid_reg, suspend_reg, rank_reg, 5'h0};
			OFF_CFG_HIGH: rd_value = {17'h0, dst_port_reg, src_port_reg, 7'h0};
			default: rd_value = 32'h0;
		endcase
	end

	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			prdata <= 32'h0;
			pready <= 1'b0;
			pslverr <= 1'b0;
		end else if (clk_en) begin
			pready <= psel && !penable;
			pslverr <= psel && !penable && !is_mapped(paddr);
			if (psel && !penable) begin
				prdata <= rd_value;
			end
		end
	end

	// ****************************************
	// Software registers
	// ****************************************
	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			{enable_reg, wb_en_reg, src_mem_reg, dst_mem_reg, sw_src_reg, sw_dst_reg} <= 6'h0;
			flow_reg <= FLOW_DMA;
			width_reg <= 3'h0;
			block_size_reg <= RST_CTL_HIGH[CTL_CNT_W-1:0];
			src_pol_reg <= RST_CFG_LOW[CFG_SRC_POL_BIT];
			dst_pol_reg <= RST_CFG_LOW[CFG_DST_POL_BIT];
			src_sel_reg <= RST_CFG_LOW[CFG_SRC_SEL_BIT];
			dst_sel_reg <= RST_CFG_LOW[CFG_DST_SEL_BIT];
			suspend_reg <= RST_CFG_LOW[CFG_SUSP_BIT];
			rank_reg <= RST_CFG_LOW[CFG_RANK_LSB+:3];
			src_port_reg <= 4'h0;
			dst_port_reg <= 4'h0;
			item_addr_reg <= 32'h0;
			irq_mask_reg <= 2'h0;
		end else if (clk_en) begin
			if (finish) begin
				enable_reg <= 1'b0;
			end
			if (wr) begin
				unique case (paddr)
					OFF_CTRL: begin
						enable_reg <= pwdata[CTRL_EN_BIT];
						wb_en_reg <= pwdata[CTRL_WB_BIT];
						src_mem_reg <= pwdata[CTRL_SRC_MEM_BIT];
						dst_mem_reg <= pwdata[CTRL_DST_MEM_BIT];
						flow_reg <= pwdata[CTRL_FLOW_LSB+:2];
						width_reg <= pwdata[CTRL_WIDTH_LSB+:3];
						sw_src_reg <= pwdata[CTRL_SW_SRC_BIT];
						sw_dst_reg <= pwdata[CTRL_SW_DST_BIT];
					end
					OFF_ITEM_ADDR: item_addr_reg <= {pwdata[31:2], 2'h0};
					OFF_IRQ_MASK: irq_mask_reg <= pwdata[1:0];
					OFF_CTL_HIGH: block_size_reg <= pwdata[CTL_CNT_W-1:0];
					OFF_CFG_LOW: begin
						src_pol_reg <= pwdata[CFG_SRC_POL_BIT];
						dst_pol_reg <= pwdata[CFG_DST_POL_BIT];
						src_sel_reg <= pwdata[CFG_SRC_SEL_BIT];
						dst_sel_reg <= pwdata[CFG_DST_SEL_BIT];
						suspend_reg <= pwdata[CFG_SUSP_BIT];
						rank_reg <= pwdata[CFG_RANK_LSB+:3];
					end
					OFF_CFG_HIGH: begin
						src_port_reg <= pwdata[CFGH_SRC_PORT_LSB+:4];
						dst_port_reg <= pwdata[CFGH_DST_PORT_LSB+:4];
					end
					default: ;
				endcase
			end
		end
	end

	// ****************************************
	// Done flag and interrupts
	// ****************************************
	assign irq_set[IRQ_BLOCK_BIT] = finish;
	assign irq_set[IRQ_WB_BIT] = finish && (state_reg == ST_WBACK);

	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			done_reg <= RST_CTL_HIGH[CTL_DONE_BIT];
			irq_stat_reg <= 2'h0;
			irq <= 1'b0;
			block_done <= 1'b0;
		end else if (clk_en) begin
			// A set in the same cycle as a clear or write is kept
			if (wr && wr_to(paddr, OFF_CTL_HIGH)) begin
				done_reg <= pwdata[CTL_DONE_BIT] || finish;
			end else if (finish) begin
				done_reg <= 1'b1;
			end
			// Only bits that were returned by the read get cleared
			if (rd && wr_to(paddr, OFF_IRQ_STAT)) begin
				irq_stat_reg <= (irq_stat_reg & ~prdata[1:0]) | irq_set;
			end else begin
				irq_stat_reg <= irq_stat_reg | irq_set;
			end
			irq <= |(irq_stat_reg & irq_mask_reg);
			block_done <= finish;
		end
	end

	// ****************************************
	// Transfer engine
	// ****************************************
	always_comb begin
		finish = 1'b0;
		if (link.s_ready && link.m_valid) begin
			if (state_reg == ST_WBACK) begin
				finish = 1'b1;
			end else if (state_reg == ST_WRITE && !wb_en_reg &&
				(last_reg || (flow_reg == FLOW_DST && link.dst_last))) begin
				finish = 1'b1;
			end
		end
	end

	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			state_reg <= ST_IDLE;
			link.m_valid <= 1'b0;
			link.m_write <= 1'b0;
			link.m_size <= 3'h0;
			link.m_addr <= 32'h0;
			link.m_wdata <= 32'h0;
			link.bus_req <= 1'b0;
			link.bus_rank <= RST_CFG_LOW[CFG_RANK_LSB+:3];
			src_addr_reg <= 32'h0;
			dst_addr_reg <= 32'h0;
			cnt_reg <= 10'h0;
			started_reg <= 1'b0;
			last_reg <= 1'b0;
			hold_valid_reg <= 1'b0;
			hold_reg <= 32'h0;
		end else if (clk_en) begin
			link.bus_rank <= rank_reg;
			if (wr && wr_to(paddr, OFF_SRC_ADDR)) begin
				src_addr_reg <= pwdata;
			end
			if (wr && wr_to(paddr, OFF_DST_ADDR)) begin
				dst_addr_reg <= pwdata;
			end
			if (start) begin
				cnt_reg <= 10'h0;
				started_reg <= 1'b1;
				last_reg <= 1'b0;
			end
			unique case (state_reg)
				ST_IDLE: begin
					link.bus_req <= want_rd || want_wr;
					if (link.bus_req && link.bus_gnt && want_wr) begin
						link.m_valid <= 1'b1;
						link.m_write <= 1'b1;
						link.m_size <= width_reg;
						link.m_addr <= dst_addr_reg;
						link.m_wdata <= hold_reg;
						state_reg <= ST_WRITE;
					end else if (link.bus_req && link.bus_gnt && want_rd) begin
						link.m_valid <= 1'b1;
						link.m_write <= 1'b0;
						link.m_size <= width_reg;
						link.m_addr <= src_addr_reg;
						state_reg <= ST_READ;
					end
				end
				ST_READ: begin
					if (link.s_ready) begin
						link.m_valid <= 1'b0;
						hold_reg <= link.s_rdata;
						hold_valid_reg <= 1'b1;
						if (flow_reg == FLOW_DMA || cnt_reg != CNT_MAX) begin
							cnt_reg <= cnt_reg + 10'h1;
						end
						if ((flow_reg == FLOW_DMA && cnt_reg + 10'h1 >= block_size_reg) ||
							(flow_reg == FLOW_SRC && link.src_last)) begin
							last_reg <= 1'b1;
						end
						if (src_mem_reg) begin
							src_addr_reg <= src_addr_reg + step;
						end
						state_reg <= ST_IDLE;
					end
				end
				ST_WRITE: begin
					if (link.s_ready) begin
						link.m_valid <= 1'b0;
						hold_valid_reg <= 1'b0;
						if (dst_mem_reg) begin
							dst_addr_reg <= dst_addr_reg + step;
						end
						state_reg <= ST_IDLE;
						if (last_reg || (flow_reg == FLOW_DST && link.dst_last)) begin
							last_reg <= 1'b0;
							if (wb_en_reg) begin
								link.m_valid <= 1'b1;
								link.m_write <= 1'b1;
								link.m_size <= ITEM_SIZE;
								link.m_addr <= item_addr_reg;
								link.m_wdata <= ctl_high_word | (32'h1 << CTL_DONE_BIT);
								state_reg <= ST_WBACK;
							end
						end
					end
				end
				ST_WBACK: begin
					if (link.s_ready) begin
						link.m_valid <= 1'b0;
						state_reg <= ST_IDLE;
					end
				end
			endcase
		end
	end

endmodule
`default_nettype wire

// ===== rtl/dmac_peer.sv
// Partner end: request lines, bus grant by rank, word memory
`timescale 1ns/1ps
`default_nettype none
module dmac_peer
	import dmac_pkg::*;
(
	input wire logic core_clk,
	input wire logic resetn,
	input wire logic clk_en,
	input wire logic [15:0] src_req_in,
	input wire logic [15:0] dst_req_in,
	input wire logic src_last_in,
	input wire logic dst_last_in,
	input wire logic other_req,
	input wire logic [2:0] other_rank,
	input wire logic load_en,
	input wire logic [3:0] load_idx,
	input wire logic [31:0] load_data,
	output logic wr_seen,
	output logic [31:0] wr_addr,
	output logic [31:0] wr_data,
	output logic [2:0] wr_size,
	dmac_link_if.peer link
);
	logic [31:0] mem [MEM_DEPTH];
	logic [3:0] idx;

	assign idx = link.m_addr[5:2];

	// ****************************************
	// Requests and arbitration
	// ****************************************
	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			link.hw_src_req <= 16'h0;
			link.hw_dst_req <= 16'h0;
			link.src_last <= 1'b0;
			link.dst_last <= 1'b0;
			link.bus_gnt <= 1'b0;
		end else if (clk_en) begin
			link.hw_src_req <= src_req_in;
			link.hw_dst_req <= dst_req_in;
			link.src_last <= src_last_in;
			link.dst_last <= dst_last_in;
			// Ties go to the channel; higher rank wins
			link.bus_gnt <= link.bus_req && (!other_req || link.bus_rank >= other_rank);
		end
	end

	// ****************************************
	// Memory responder
	// ****************************************
	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			link.s_ready <= 1'b0;
			link.s_rdata <= 32'h0;
			wr_seen <= 1'b0;
			wr_addr <= 32'h0;
			wr_data <= 32'h0;
			wr_size <= 3'h0;
		end else if (clk_en) begin
			link.s_ready <= link.m_valid && !link.s_ready;
			wr_seen <= 1'b0;
			if (link.m_valid && !link.s_ready) begin
				link.s_rdata <= mem[idx];
				if (link.m_write) begin
					wr_seen <= 1'b1;
					wr_addr <= link.m_addr;
					wr_data <= link.m_wdata;
					wr_size <= link.m_size;
				end
			end
		end
	end

	genvar g;
	generate
		for (g = 0; g < MEM_DEPTH; g++) begin : g_word
			always_ff @(posedge core_clk or negedge resetn) begin
				if (!resetn) begin
					mem[g] <= 32'h0;
				end else if (clk_en) begin
					if (link.m_valid && !link.s_ready && link.m_write && idx == 4'(g)) begin
						mem[g] <= link.m_wdata;
					end else if (load_en && load_idx == 4'(g)) begin
						mem[g] <= load_data;
					end
				end
			end
		end
	endgenerate
endmodule
`default_nettype wire

// ===== tb/dmac_assertions.sv
// Link checks between the DMA channel and its partner
`timescale 1ns/1ps
`default_nettype none
module dmac_assertions (
	input wire logic core_clk,
	input wire logic resetn,
	input wire logic bus_req,
	input wire logic bus_gnt,
	input wire logic m_valid,
	input wire logic m_write,
	input wire logic [2:0] m_size,
	input wire logic [31:0] m_addr,
	input wire logic [31:0] m_wdata,
	input wire logic s_ready,
	input wire logic other_req
);
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!resetn);
	// Bench moves byte items only, so a size-2 write is a write-back
	wire logic wb = m_valid && m_write && m_size == 3'h2;
	req_hold_a: assert property (m_valid && !s_ready |=> m_valid && $stable(m_addr) && $stable(m_wdata))
		else $error("Link request changed before ready");
	ready_pulse_a: assert property (s_ready |=> !s_ready)
		else $error("Ready longer than one cycle");
	ready_answer_a: assert property ($rose(m_valid) |-> !s_ready ##1 s_ready)
		else $error("Ready not one cycle after request");
	grant_gate_a: assert property ($rose(m_valid) && !wb |-> $past(bus_req) && $past(bus_gnt))
		else $error("Request issued without grant");
	grant_follow_a: assert property ($rose(bus_req) && !other_req |=> bus_gnt)
		else $error("Grant late for a lone requester");
	wb_flag_a: assert property (wb |-> m_wdata[12])
		else $error("Write-back word without done flag");
	wb_align_a: assert property (wb |-> m_addr[1:0] == 2'h0)
		else $error("Write-back not word aligned");
	wb_rsvd_a: assert property (wb |-> m_wdata[31:13] == 19'h0 && m_wdata[11:10] == 2'h0)
		else $error("Write-back reserved bits set");
	cover property (wb);
	cover property ($rose(m_valid) && !m_write);
	cover property (s_ready && m_write);
endmodule
`default_nettype wire

// ===== tb/dmac_channel_block_ctrl_cfg_tb.sv
// Self-checking bench for the DMA channel joined to its partner
`timescale 1ns/1ps
`default_nettype none
module dmac_channel_block_ctrl_cfg_tb;
	import dmac_pkg::*;
	logic core_clk = 1'b0;
	logic resetn = 1'b0;
	logic clk_en = 1'b1;
	logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0, prdata, rd, wr_addr, wr_data, load_data = 32'h0;
	logic pready, pslverr, irq, block_done, err, wr_seen, src_last = 1'b0, load_en = 1'b0;
	logic dst_last = 1'b0, other_req = 1'b0;
	logic [15:0] src_req = 16'h0, dst_req = 16'h0;
	logic [3:0] load_idx = 4'h0;
	logic [2:0] wr_size, other_rank = 3'h0;
	int fails = 0, total_checks = 0, reads = 0;
	dmac_link_if lk();
	dmac_channel dmac_channel_i (.core_clk(core_clk), .resetn(resetn), .clk_en(clk_en), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .irq(irq), .block_done(block_done), .link(lk));
	dmac_peer dmac_peer_i (.core_clk(core_clk), .resetn(resetn), .clk_en(clk_en), .src_req_in(src_req),
		.dst_req_in(dst_req), .src_last_in(src_last), .dst_last_in(dst_last), .other_req(other_req),
		.other_rank(other_rank),
		.load_en(load_en), .load_idx(load_idx), .load_data(load_data), .wr_seen(wr_seen), .wr_addr(wr_addr),
		.wr_data(wr_data), .wr_size(wr_size), .link(lk));
	dmac_assertions dmac_assertions_i (.core_clk(core_clk), .resetn(resetn), .bus_req(lk.bus_req),
		.bus_gnt(lk.bus_gnt), .m_valid(lk.m_valid), .m_write(lk.m_write), .m_size(lk.m_size),
		.m_addr(lk.m_addr), .m_wdata(lk.m_wdata), .s_ready(lk.s_ready), .other_req(other_req));
	always #4 core_clk = ~core_clk;
	always @(posedge core_clk) begin
		if (lk.m_valid && !lk.m_write && lk.s_ready)
			reads++;
	end
	// ****************************************
	// Shared tasks
	// ****************************************
	task automatic give_verdict();
		$display("Checks %0d mismatches %0d", total_checks, fails);
		if (fails == 0 && total_checks > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
		total_checks++;
		if (seen !== exp) begin
			fails++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic cycles(input int n);
		repeat (n) @(posedge core_clk);
	endtask
	// Ends one idle edge after the access so calls can follow back to back
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		int n;
		n = 0;
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge core_clk);
		penable <= 1'b1;
		do begin
			@(posedge core_clk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		if (n >= 20) begin
			fails++;
			give_verdict();
		end
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge core_clk);
	endtask
	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
	endtask
	task automatic rdchk(input string what, input logic [11:0] a, input logic [31:0] exp);
		apb(1'b0, a, 32'h0);
		chk(what, rd, exp);
	endtask
	task automatic wait_reads(input int k);
		for (int n = 0; reads < k || block_done !== 1'b1; n++) begin
			@(posedge core_clk);
			if (n > 30000) begin
				fails++;
				give_verdict();
			end
		end
	endtask
	// ****************************************
	// Scenarios
	// ****************************************
	task automatic t_regs();
		rdchk("ctl reset", OFF_CTL_HIGH, RST_CTL_HIGH);
		rdchk("cfg reset", OFF_CFG_LOW, RST_CFG_LOW);
		chk("rank reset", {29'h0, lk.bus_rank}, 32'h1);
		wr(OFF_CFG_LOW, 32'hFFFF_FF1F);
		rdchk("cfg ones", OFF_CFG_LOW, 32'h000C_0F00);
		chk("rank zero", {29'h0, lk.bus_rank}, 32'h0);
		wr(OFF_CFG_LOW, 32'h0000_0040);
		wr(OFF_CTL_HIGH, 32'hFFFF_FFFF);
		rdchk("ctl ones", OFF_CTL_HIGH, 32'h0000_13FF);
		apb(1'b0, 12'h040, 32'h0);
		chk("unmapped err", {31'h0, err}, 32'h1);
		chk("unmapped data", rd, 32'h0);
		chk("rank two", {29'h0, lk.bus_rank}, 32'h2);
		$display("registers test done");
	endtask
	task automatic t_block();
		load_data <= 32'h0000_00A5;
		load_en <= 1'b1;
		@(posedge core_clk);
		load_en <= 1'b0;
		wr(OFF_IRQ_MASK, 32'h1);
		wr(OFF_DST_ADDR, 32'h10);
		wr(OFF_ITEM_ADDR, 32'h23);
		wr(OFF_CTL_HIGH, 32'h3);
		reads = 0;
		wr(OFF_CTRL, 32'hF);
		wait_reads(0);
		cycles(2);
		chk("dma reads", 32'(reads), 32'h3);
		chk("wb addr", wr_addr, 32'h20);
		chk("wb size", {29'h0, wr_size}, 32'h2);
		chk("wb word", wr_data, 32'h1003);
		chk("irq set", {31'h0, irq}, 32'h1);
		rdchk("count", OFF_CTL_HIGH, 32'h1003);
		rdchk("status", OFF_IRQ_STAT, 32'h3);
		cycles(1);
		chk("irq clear", {31'h0, irq}, 32'h0);
		rdchk("status clear", OFF_IRQ_STAT, 32'h0);
		$display("block test done");
	endtask
	task automatic t_suspend();
		wr(OFF_CFG_LOW, 32'h0000_0140);
		wr(OFF_CTL_HIGH, 32'h2);
		reads = 0;
		wr(OFF_CTRL, 32'hD);
		cycles(30);
		chk("suspended", 32'(reads), 32'h0);
		rdchk("empty", OFF_CFG_LOW, 32'h0000_0340);
		// A higher-ranked rival holds the bus until it drops to a tie
		other_req <= 1'b1;
		other_rank <= 3'h3;
		wr(OFF_CFG_LOW, 32'h0000_0040);
		cycles(30);
		chk("outranked", 32'(reads), 32'h0);
		other_rank <= 3'h2;
		wait_reads(2);
		other_req <= 1'b0;
		chk("resumed", 32'(reads), 32'h2);
		$display("suspend test done");
	endtask
	task automatic t_handshake();
		// Only the selected line differs from the rest, so a wrong port or polarity shows
		src_req <= 16'h0020;
		dst_req <= 16'hFFFF;
		wr(OFF_CFG_HIGH, 32'h0000_0280);
		wr(OFF_CFG_LOW, 32'h000C_0440);
		reads = 0;
		wr(OFF_CTRL, 32'h0000_0601);
		cycles(30);
		chk("hw src idle", 32'(reads), 32'h0);
		src_req <= 16'hFFDF;
		wait_reads(2);
		chk("hw src run", 32'(reads), 32'h2);
		wr(OFF_CFG_LOW, 32'h0004_0840);
		reads = 0;
		wr(OFF_CTRL, 32'h0000_0601);
		cycles(30);
		chk("hw dst idle", 32'(reads), 32'h1);
		rdchk("not empty", OFF_CFG_LOW, 32'h0004_0840);
		dst_req <= 16'hFFFE;
		wait_reads(2);
		chk("hw dst run", 32'(reads), 32'h2);
		$display("handshake test done");
	endtask
	task automatic t_saturate();
		wr(OFF_CFG_LOW, 32'h0000_0C40);
		reads = 0;
		wr(OFF_CTRL, 32'h0000_0611);
		for (int n = 0; reads < 1030; n++) begin
			@(posedge core_clk);
			if (n > 30000) begin
				fails++;
				give_verdict();
			end
		end
		rdchk("saturated", OFF_CTL_HIGH, 32'h13FF);
		src_last <= 1'b1;
		wait_reads(0);
		src_last <= 1'b0;
		dst_last <= 1'b1;
		reads = 0;
		wr(OFF_CTRL, 32'h0000_0621);
		wait_reads(0);
		dst_last <= 1'b0;
		chk("dst flow reads", 32'(reads), 32'h1);
		rdchk("dst flow count", OFF_CTL_HIGH, 32'h1001);
		$display("saturation test done");
	endtask
	initial begin
		repeat (2) @(posedge core_clk);
		resetn <= 1'b1;
		@(posedge core_clk);
		t_regs();
		t_block();
		t_suspend();
		t_handshake();
		t_saturate();
		give_verdict();
	end
endmodule
`default_nettype wire
